// File: src/rsg_rx_signaling.sv
// Receive signaling: capture, change of state, freeze, backplane stream
// Assumes line strobes on aclk; backplane clock and sync are async pins
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module rsg_rx_signaling import rsg_pkg::*; #(
	parameter int HOLD_ESF_CYC = HOLD_ESF_DEF,
	parameter int HOLD_D4_CYC  = HOLD_D4_DEF,
	parameter int HOLD_E1_CYC  = HOLD_E1_DEF
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite register slave
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Line-side framer
	input  wire rsg_line_s   lin,
	// Backplane
	input  wire logic        rx_backplane_clock,
	input  wire logic        rx_multiframe_sync,
	input  wire logic        es_data_in,
	output logic             rx_sig_stream_out,
	output logic             rx_serial_data_out,
	// Indications
	output logic             freeze_indicator,
	output logic             irq_n
);

	// ========================================================
	// State
	typedef struct packed {
		logic [7:0]                      ctrl;
		logic                            sts_cos;
		logic                            msk_cos;
		logic [31:0]                     cen;
		logic [31:0]                     cst;
		logic [31:0]                     rsel;
		logic [31:0]                     aone;
		logic [NCH-1:0][3:0]             stg;
		logic [NCH-1:0][3:0]             rsig;
		logic [NCH-1:0][3:0]             cand;
		logic [NCH-1:0][3:0]             rpt;
		logic [NCH-1:0][1:0]             cnt;
		logic [BUF_MF-1:0][NCH-1:0][3:0] sbuf;
		logic [1:0]                      wp;
		logic [19:0]                     hold;
		logic [2:0]                      ck_s;
		logic [2:0]                      sy_s;
		logic                            ck_l;
		logic                            sy_l;
		logic                            sy_p;
		logic [8:0]                      pos;
		logic [4:0]                      fr;
		logic                            sig_o;
		logic                            ser_o;
		logic                            frz_o;
		logic                            irq_n;
		logic                            aw_f;
		logic                            w_f;
		logic [7:0]                      awa;
		logic [31:0]                     wd;
		logic [3:0]                      ws;
		logic                            awready;
		logic                            wready;
		logic                            bvalid;
		logic [1:0]                      bresp;
		logic                            arready;
		logic                            rvalid;
		logic [31:0]                     rdata;
		logic [1:0]                      rresp;
	} rsg_st_s;

	rsg_st_s st;
	rsg_st_s next_st;
	logic    frz;
	logic    bpe;
	logic    clr_cos;

	// ========================================================
	// Next-state logic
	always_comb begin
		logic        wr;
		logic        chg;
		logic        fbit;
		logic        hit;
		logic        rb;
		logic        sig;
		logic        ser;
		logic        ren;
		logic        t1;
		logic        mf;
		logic        cond;
		logic        sye;
		logic [31:0] m;
		logic [31:0] rd;
		logic [7:0]  a;
		logic [1:0]  rr;
		logic [1:0]  k;
		logic [8:0]  np;
		logic [8:0]  off;
		logic [8:0]  flen;
		logic [4:0]  nfr;
		logic [4:0]  nmf;
		logic [4:0]  ch;
		logic [4:0]  rch;
		logic [2:0]  bn;
		logic [3:0]  nw;
		logic [3:0]  nib;
		logic [19:0] hl;
		wr = 1'b0;
		chg = 1'b0;
		fbit = 1'b0;
		hit = 1'b0;
		rb = 1'b0;
		sig = 1'b0;
		ser = 1'b0;
		ren = 1'b0;
		t1 = 1'b0;
		mf = 1'b0;
		cond = 1'b0;
		sye = 1'b0;
		m = 32'h0;
		rd = 32'h0;
		a = 8'h0;
		rr = RESP_OK;
		k = 2'h0;
		np = 9'h0;
		off = 9'h0;
		flen = 9'h0;
		nfr = 5'h0;
		nmf = 5'h0;
		ch = 5'h0;
		rch = 5'h0;
		bn = 3'h0;
		nw = 4'h0;
		nib = 4'h0;
		hl = 20'h0;
		next_st = st;

		// Bus write channels, address and data in either order
		if (awvalid && st.awready) begin
			next_st.aw_f = 1'b1;
			next_st.awa = awaddr;
		end
		if (wvalid && st.wready) begin
			next_st.w_f = 1'b1;
			next_st.wd = wdata;
			next_st.ws = wstrb;
		end
		if (bready && st.bvalid)
			next_st.bvalid = 1'b0;
		wr = st.aw_f && st.w_f && !st.bvalid;
		a = {st.awa[7:2], 2'h0};
		m = {{8{st.ws[3]}}, {8{st.ws[2]}}, {8{st.ws[1]}}, {8{st.ws[0]}}};
		clr_cos = wr && a == A_STS && m[S_COS] && st.wd[S_COS];
		// Register write decode; clears come before hardware sets
		if (wr) begin
			next_st.aw_f = 1'b0;
			next_st.w_f = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OK;
			if (a == A_CTRL)
				next_st.ctrl = (st.ctrl & ~m[7:0]) | (st.wd[7:0] & m[7:0]);
			else if (a == A_STS) begin
				if (clr_cos)
					next_st.sts_cos = 1'b0;
			end else if (a == A_MSK) begin
				if (m[S_COS])
					next_st.msk_cos = st.wd[S_COS];
			end else if (a == A_CEN)
				next_st.cen = (st.cen & ~m) | (st.wd & m);
			else if (a == A_CST)
				next_st.cst = st.cst & ~(st.wd & m);
			else if (a == A_RSEL)
				next_st.rsel = (st.rsel & ~m) | (st.wd & m);
			else if (a == A_AONE)
				next_st.aone = ((st.aone & ~m) | (st.wd & m)) & AONE_MASK;
			else if (a != A_FRZ && a < A_SIG)
				next_st.bresp = RESP_ERR;
		end

		// Bus read channel
		if (rready && st.rvalid)
			next_st.rvalid = 1'b0;
		if (arvalid && st.arready) begin
			a = {araddr[7:2], 2'h0};
			if (a >= A_SIG)
				rd = {28'h0, st.rsig[a[6:2]]};
			else if (a == A_CTRL)
				rd = {24'h0, st.ctrl};
			else if (a == A_STS)
				rd = {28'h0, st.sts_cos, 3'h0};
			else if (a == A_MSK)
				rd = {28'h0, st.msk_cos, 3'h0};
			else if (a == A_CEN)
				rd = st.cen;
			else if (a == A_CST)
				rd = st.cst;
			else if (a == A_RSEL)
				rd = st.rsel;
			else if (a == A_AONE)
				rd = st.aone;
			else if (a == A_FRZ)
				rd = {31'h0, st.frz_o};
			else
				rr = RESP_ERR;
			next_st.rvalid = 1'b1;
			next_st.rdata = rd;
			next_st.rresp = rr;
		end
		next_st.awready = !next_st.aw_f && !next_st.bvalid;
		next_st.wready = !next_st.w_f && !next_st.bvalid;
		next_st.arready = !next_st.rvalid;

		// Freeze control and post-fault hold
		cond = lin.out_of_frame || lin.loss_of_frame
			|| lin.carrier_loss || lin.align_change;
		if (st.ctrl[5:4] == RSG_E1)
			hl = 20'(HOLD_E1_CYC);
		else if (st.ctrl[5:4] == RSG_D4)
			hl = 20'(HOLD_D4_CYC);
		else
			hl = 20'(HOLD_ESF_CYC);
		if (cond)
			next_st.hold = hl;
		else if (st.hold != 20'h0)
			next_st.hold = st.hold - 20'h1;
		frz = st.ctrl[C_FF]
			|| (st.ctrl[C_FE] && (cond || st.hold != 20'h0));
		next_st.frz_o = frz;

		// Per-channel staging during the multiframe
		if (lin.sig_valid)
			next_st.stg[lin.sig_ch] = lin.sig_abcd;
		mf = lin.mf_end && !(lin.out_of_frame || lin.loss_of_frame);
		if (mf) begin
			next_st.rsig = st.stg;
			for (int i = 0; i < NCH; i++) begin
				nw = st.stg[i];
				// One global integration bit for all channels
				if (st.ctrl[C_INTEG]) begin
					if (nw != st.cand[i]) begin
						next_st.cand[i] = nw;
						next_st.cnt[i] = 2'h1;
					end else if (st.cnt[i] != INTEG_MF)
						next_st.cnt[i] = st.cnt[i] + 2'h1;
					chg = nw == st.cand[i]
						&& st.cnt[i] == INTEG_MF - 2'h1
						&& nw != st.rpt[i];
				end else begin
					next_st.cand[i] = nw;
					next_st.cnt[i] = 2'h1;
					chg = nw != st.rpt[i];
				end
				if (chg) begin
					next_st.rpt[i] = nw;
					next_st.cst[i] = 1'b1;
					if (st.cen[i])
						next_st.sts_cos = 1'b1;
				end
			end
			// Buffer advances only while not frozen
			if (!frz) begin
				next_st.sbuf[st.wp] = st.stg;
				next_st.wp = st.wp + 2'h1;
			end
		end

		// Backplane pin synchronisers and edge detection
		next_st.ck_s = {st.ck_s[1:0], rx_backplane_clock};
		next_st.sy_s = {st.sy_s[1:0], rx_multiframe_sync};
		if (st.ck_s[2] == st.ck_s[1])
			next_st.ck_l = st.ck_s[1];
		if (st.sy_s[2] == st.sy_s[1])
			next_st.sy_l = st.sy_s[1];
		bpe = next_st.ck_l && !st.ck_l;
		sye = next_st.sy_l && !st.sy_l;
		if (sye)
			next_st.sy_p = 1'b1;

		// Backplane position within frame and multiframe
		t1 = st.ctrl[5:4] != RSG_E1;
		flen = st.ctrl[C_BP2M] ? FLEN_E1 : FLEN_T1;
		if (st.ctrl[5:4] == RSG_E1)
			nmf = NFR_E1;
		else if (st.ctrl[5:4] == RSG_D4)
			nmf = NFR_D4;
		else
			nmf = NFR_ESF;
		if (st.sy_p || sye) begin
			np = 9'h0;
			nfr = 5'h0;
		end else if (st.pos >= flen - 9'h1) begin
			np = 9'h0;
			nfr = (st.fr >= nmf - 5'h1) ? 5'h0 : st.fr + 5'h1;
		end else begin
			np = st.pos + 9'h1;
			nfr = st.fr;
		end
		fbit = !st.ctrl[C_BP2M] && np == 9'h0;
		off = st.ctrl[C_BP2M] ? np : np - 9'h1;
		ch = off[7:3];
		bn = off[2:0];
		nib = st.sbuf[st.wp][ch];

		// Signaling stream bit, lower nibble only
		if (!fbit && bn[2]) begin
			if (st.ctrl[5:4] == RSG_D4)
				sig = nib[{1'b1, ~bn[0]}];
			else
				sig = nib[~bn[1:0]];
		end

		// Reinsertion positions in the backplane multiframe
		case (nfr)
			5'h05: k = 2'h0;
			5'h0B: k = 2'h1;
			5'h11: k = 2'h2;
			5'h17: k = 2'h3;
			default: k = 2'h0;
		endcase
		if (t1) begin
			rch = ch;
			hit = !fbit && bn == 3'h7 && (nfr == 5'h05 || nfr == 5'h0B
				|| nfr == 5'h11 || nfr == 5'h17);
			rb = nib[~k];
		end else begin
			rch = {bn[2], nfr[3:0]};
			hit = ch == TS_SIG && nfr != 5'h0 && nfr < NFR_E1;
			rb = st.sbuf[st.wp][rch][~bn[1:0]];
		end
		ren = st.ctrl[C_ES]
			&& !(!t1 && !st.ctrl[C_BP2M]);
		ser = es_data_in;
		if (hit && ren && st.rsel[rch])
			ser = rb;
		if (t1 && hit && st.aone[ch])
			ser = 1'b1;
		if (bpe) begin
			next_st.pos = np;
			next_st.fr = nfr;
			next_st.sy_p = 1'b0;
			next_st.sig_o = sig;
			next_st.ser_o = ser;
		end

		// Interrupt output from sticky masked status
		next_st.irq_n = !(st.sts_cos && st.msk_cos);
	end

	// ========================================================
	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.ctrl <= CTRL_RST;
			st.irq_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign awready = st.awready;
	assign wready = st.wready;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign arready = st.arready;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
	assign rx_sig_stream_out = st.sig_o;
	assign rx_serial_data_out = st.ser_o;
	assign freeze_indicator = st.frz_o;
	assign irq_n = st.irq_n;

	// ========================================================
	// Checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_cap_boundary: assert property (
		$changed(st.rsig) |-> $past(lin.mf_end))
		else $error("signaling registers changed off boundary");
	chk_los_hold: assert property (
		lin.mf_end && (lin.out_of_frame || lin.loss_of_frame)
		|=> $stable(st.rsig))
		else $error("signaling registers updated in loss of sync");
	chk_cos_cause: assert property (
		$rose(st.sts_cos) |-> (st.cst & st.cen) != 32'h0)
		else $error("status set without enabled channel change");
	chk_cst_track: assert property (
		$changed(st.rpt) |-> st.cst != 32'h0)
		else $error("change not recorded in change status");
	chk_integ_three: assert property (
		st.ctrl[C_INTEG] && $past(st.ctrl[C_INTEG])
		&& st.rpt[0] != $past(st.rpt[0])
		|-> $past(st.cnt[0]) == 2'h2 && $past(st.cand[0]) == st.rpt[0])
		else $error("integrated change reported too early");
	chk_irq_level: assert property (
		irq_n == !$past(st.sts_cos && st.msk_cos))
		else $error("interrupt does not follow masked status");
	chk_cos_sticky: assert property (
		st.sts_cos && !clr_cos |=> st.sts_cos)
		else $error("status bit dropped without clear");
	chk_force_frz: assert property (
		st.ctrl[C_FF] |=> freeze_indicator && $stable(st.wp))
		else $error("force freeze not effective");
	chk_buf_frozen: assert property (
		st.ctrl[C_FE] && (lin.out_of_frame || lin.carrier_loss)
		|=> $stable(st.wp) ##1 freeze_indicator)
		else $error("buffer advanced during enabled freeze");
	chk_hold_after: assert property (
		(lin.carrier_loss && st.ctrl[C_FE]) ##1 st.ctrl[C_FE] [*8]
		|-> ##1 freeze_indicator)
		else $error("freeze released too early");
	chk_e1_no_rein: assert property (
		bpe && st.ctrl[5:4] == RSG_E1 && !st.ctrl[C_BP2M]
		|=> rx_serial_data_out == $past(es_data_in))
		else $error("E1 reinsertion on slow backplane");
	chk_no_es_pass: assert property (
		bpe && !st.ctrl[C_ES] && st.aone == 32'h0
		|=> rx_serial_data_out == $past(es_data_in))
		else $error("reinsertion without elastic store");

	cov_cos_set: cover property ($rose(st.sts_cos));
	cov_irq_low: cover property ($fell(irq_n));
	cov_freeze: cover property ($rose(freeze_indicator));
	cov_reinsert: cover property (bpe && st.ctrl[C_ES] ##1 rx_serial_data_out);

endmodule

`default_nettype wire

// File: src/rsg_pkg.sv
// Constants, types and register map for the receive signaling block
// Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus
package rsg_pkg;

	// ========================================================
	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STS  = 8'h04;
	localparam logic [7:0] A_MSK  = 8'h08;
	localparam logic [7:0] A_CEN  = 8'h0C;
	localparam logic [7:0] A_CST  = 8'h10;
	localparam logic [7:0] A_RSEL = 8'h14;
	localparam logic [7:0] A_AONE = 8'h18;
	localparam logic [7:0] A_FRZ  = 8'h1C;
	localparam logic [7:0] A_SIG  = 8'h80;

	// ========================================================
	// Field positions and reset values
	localparam int C_INTEG = 0;
	localparam int C_FE    = 1;
	localparam int C_FF    = 2;
	localparam int C_ES    = 6;
	localparam int C_BP2M  = 7;
	localparam int S_COS   = 3;
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [31:0] AONE_MASK = 32'h00FF_FFFF;
	localparam logic [1:0]  RESP_OK   = 2'h0;
	localparam logic [1:0]  RESP_ERR  = 2'h2;

	// ========================================================
	// Framing modes, held in control bits 5:4
	typedef enum logic [1:0] {
		RSG_ESF = 2'b00,
		RSG_D4  = 2'b01,
		RSG_E1  = 2'b10
	} rsg_mode_e;

	// ========================================================
	// Frame and multiframe geometry
	localparam int         NCH      = 32;
	localparam int         BUF_MF   = 4;
	localparam logic [1:0] INTEG_MF = 2'h3;
	localparam logic [8:0] FLEN_T1  = 9'h0C1;
	localparam logic [8:0] FLEN_E1  = 9'h100;
	localparam logic [4:0] NFR_ESF  = 5'h18;
	localparam logic [4:0] NFR_D4   = 5'h0C;
	localparam logic [4:0] NFR_E1   = 5'h10;
	localparam logic [4:0] TS_SIG   = 5'h10;

	// ========================================================
	// Freeze hold times after the fault clears
	localparam int CLK_NS       = 10;
	localparam int HOLD_ESF_US  = 9000;
	localparam int HOLD_D4_US   = 4500;
	localparam int HOLD_E1_US   = 6000;
	localparam int HOLD_ESF_DEF = (HOLD_ESF_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_D4_DEF  = (HOLD_D4_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_E1_DEF  = (HOLD_E1_US * 1000 + CLK_NS - 1) / CLK_NS;

	// ========================================================
	// Line-side framer strobes
	typedef struct packed {
		logic       mf_end;
		logic       sig_valid;
		logic [4:0] sig_ch;
		logic [3:0] sig_abcd;
		logic       out_of_frame;
		logic       loss_of_frame;
		logic       carrier_loss;
		logic       align_change;
	} rsg_line_s;

endpackage

// File: tb/rsg_bp_model.sv
// Backplane side model: free-running backplane clock and multiframe sync
// Assumes the bench calls send_sync to mark the start of a multiframe
`timescale 1ns/1ps
`default_nettype none
module rsg_bp_model (
	// Backplane pins
	output logic bp_clk,
	output logic mf_sync
);
	// ========================================================
	// Clock runs free, phase unrelated to the core clock
	initial begin
		bp_clk = 1'b0;
		mf_sync = 1'b0;
		#3.3;
		forever #80 bp_clk = ~bp_clk;
	end

	// Sync pulse lasts half a backplane period
	always @(posedge bp_clk) mf_sync <= 1'b0;

	// Raise sync on a falling edge, ahead of position 0
	task automatic send_sync();
		@(negedge bp_clk);
		mf_sync <= 1'b1;
	endtask
endmodule
`default_nettype wire

// File: tb/tb_rsg_rx_signaling.sv
// Self-checking bench for the receive signaling block
// Assumes rsg_pkg, the design and the backplane model compile first
`timescale 1ns/1ps
`default_nettype none
module tb_rsg_rx_signaling import rsg_pkg::*;;
	// ========================================================
	// Signals and bookkeeping
	localparam int HOLD = 20;
	typedef struct {
		string       nm;
		logic [33:0] v;
	} rsg_note_s;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        es_data_in, es_rand, sig_out, ser_out, frz, irq_n;
	logic [7:0]  awaddr, araddr, rs, rr;
	logic [31:0] wdata, rdata, rnd;
	logic [1:0]  bresp, rresp;
	rsg_line_s   lin;
	wire logic   bp_clk;
	wire logic   mf_sync;
	rsg_note_s   notes[$];
	rsg_note_s   e;
	int          fail_count, n_compared;
	int          seed = 58719;

	// ========================================================
	// Design and backplane partner
	rsg_rx_signaling #(.HOLD_ESF_CYC(HOLD), .HOLD_D4_CYC(HOLD),
		.HOLD_E1_CYC(HOLD)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.lin(lin), .rx_backplane_clock(bp_clk),
		.rx_multiframe_sync(mf_sync), .es_data_in(es_data_in),
		.rx_sig_stream_out(sig_out), .rx_serial_data_out(ser_out),
		.freeze_indicator(frz), .irq_n(irq_n)
	);
	rsg_bp_model u_bp (.bp_clk(bp_clk), .mf_sync(mf_sync));

	// Core clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Random elastic-store data
	always @(posedge aclk) begin
		rnd = $random(seed);
		es_data_in <= es_rand & rnd[0];
	end

	// ========================================================
	// Checking and closing
	task automatic check(string nm, logic [33:0] seen, logic [33:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic chk1(string nm, logic seen, logic exp);
		check(nm, {33'h0, seen}, {33'h0, exp});
	endtask

	task automatic end_sim();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic timeout(string nm);
		check(nm, 34'h0, 34'h1);
		end_sim();
	endtask

	// Take the oldest note whenever a bus answer shows
	always @(posedge aclk) begin
		if ((bvalid && bready) || (rvalid && rready)) begin
			e = notes.pop_front();
			check(e.nm, bvalid ? {bresp, 32'h0} : {rresp, rdata}, e.v);
		end
	end

	// ========================================================
	// Register bus master
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = RESP_OK);
		int   n;
		logic ga, gw;
		notes.push_back('{$sformatf("write %h", a), {r, 32'h0}});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ga = 1'b0;
		gw = 1'b0;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready && !ga) begin
				awvalid <= 1'b0;
				ga = 1'b1;
			end
			if (wready && !gw) begin
				wvalid <= 1'b0;
				gw = 1'b1;
			end
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 50) timeout("write answer");
		@(posedge aclk);
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] r = RESP_OK);
		int   n;
		logic ga;
		notes.push_back('{$sformatf("read %h", a), {r, d}});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		ga = 1'b0;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready && !ga) begin
				arvalid <= 1'b0;
				ga = 1'b1;
			end
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (n == 50) timeout("read answer");
		@(posedge aclk);
	endtask

	// ========================================================
	// Line side and backplane helpers
	task automatic mf(logic [4:0] ch, logic [3:0] v, int k = 1);
		repeat (k) begin
			lin.sig_valid <= 1'b1;
			lin.sig_ch <= ch;
			lin.sig_abcd <= v;
			@(posedge aclk);
			lin.sig_valid <= 1'b0;
			lin.mf_end <= 1'b1;
			@(posedge aclk);
			lin.mf_end <= 1'b0;
			@(posedge aclk);
		end
	endtask

	task automatic wait_frz(int b);
		int n;
		for (n = 0; n < b && frz; n++) @(posedge aclk);
		if (n == b) timeout("freeze release");
	endtask

	task automatic bp_edge();
		int   n;
		logic p;
		p = bp_clk;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (bp_clk && !p) break;
			p = bp_clk;
		end
		if (n == 40) timeout("backplane edge");
	endtask

	// Sync, then collect eight bits from position pos onwards
	task automatic grab(int pos);
		int k;
		u_bp.send_sync();
		for (k = 0; k < pos + 8; k++) begin
			bp_edge();
			if (k >= pos) begin
				repeat (8) @(posedge aclk);
				rs = {rs[6:0], sig_out};
				rr = {rr[6:0], ser_out};
			end
		end
	endtask

	// ========================================================
	// Main sequence
	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		lin = '0;
		es_rand = 1'b1;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk1("irq_n", irq_n, 1'b1);
		rd(A_CTRL, 32'h0);
		rd(8'h20, 32'h0, RESP_ERR);
		wr(8'h24, 32'hFF, RESP_ERR);
		// Change of state, enabled and unmasked
		wr(A_CEN, 32'h8);
		wr(A_MSK, 32'h8);
		mf(3, 4'h5);
		rd(A_SIG + 8'h0C, 32'h5);
		rd(A_CST, 32'h8);
		rd(A_STS, 32'h8);
		chk1("irq_n", irq_n, 1'b0);
		rd(A_STS, 32'h8);
		wr(A_STS, 32'h8);
		chk1("irq_n", irq_n, 1'b1);
		wr(A_CST, 32'h8);
		// Channel outside the enables, then a masked change
		mf(9, 4'h3);
		rd(A_CST, 32'h200);
		rd(A_STS, 32'h0);
		wr(A_MSK, 32'h0);
		mf(3, 4'h6);
		rd(A_STS, 32'h8);
		chk1("irq_n", irq_n, 1'b1);
		wr(A_STS, 32'h8);
		wr(A_CST, 32'hFFFF_FFFF);
		// Integration needs three equal multiframes
		wr(A_CTRL, 32'h1);
		mf(0, 4'hA, 2);
		rd(A_CST, 32'h0);
		mf(0, 4'hA);
		rd(A_CST, 32'h1);
		wr(A_CTRL, 32'h0);
		// No capture during loss of frame
		lin.loss_of_frame <= 1'b1;
		mf(0, 4'h1);
		rd(A_SIG, 32'hA);
		lin.loss_of_frame <= 1'b0;
		// Forced freeze
		wr(A_CTRL, 32'h4);
		repeat (2) @(posedge aclk);
		chk1("freeze", frz, 1'b1);
		rd(A_FRZ, 32'h1);
		wr(A_CTRL, 32'h0);
		wait_frz(HOLD + 20);
		// Carrier loss freezes only when enabled, then holds
		lin.carrier_loss <= 1'b1;
		repeat (4) @(posedge aclk);
		chk1("freeze", frz, 1'b0);
		wr(A_CTRL, 32'h2);
		repeat (2) @(posedge aclk);
		chk1("freeze", frz, 1'b1);
		lin.carrier_loss <= 1'b0;
		repeat (HOLD - 2) @(posedge aclk);
		chk1("freeze hold", frz, 1'b1);
		wait_frz(HOLD + 20);
		wr(A_CTRL, 32'h0);
		// Signaling stream layout and delay
		mf(0, 4'hC, 5);
		grab(1);
		check("stream ESF", 34'(rs), 34'h0C);
		wr(A_CTRL, 32'h10);
		mf(0, 4'hC, 5);
		grab(1);
		check("stream D4", 34'(rs), 34'h0F);
		mf(0, 4'h3);
		grab(1);
		check("stream delay", 34'(rs), 34'h0F);
		mf(0, 4'h3, 3);
		grab(1);
		check("stream update", 34'(rs), 34'h00);
		// Reinsertion and all-ones on serial data, frame 5 channel 0
		es_rand <= 1'b0;
		wr(A_CTRL, 32'h40);
		wr(A_RSEL, 32'h1);
		mf(0, 4'hC, 5);
		grab(966);
		chk1("reinsert", rr[0], 1'b1);
		wr(A_RSEL, 32'h0);
		grab(966);
		chk1("reinsert off", rr[0], 1'b0);
		wr(A_AONE, 32'h1);
		grab(966);
		chk1("all ones", rr[0], 1'b1);
		// E1 on a slow backplane passes serial data untouched
		wr(A_AONE, 32'h0);
		wr(A_CTRL, 32'h60);
		grab(0);
		check("E1 no reinsert", 34'(rr), 34'h00);
		end_sim();
	end
endmodule
`default_nettype wire
